// ### rtl/jtxcf_regs.sv
// Operation
// - lanes equal two to lane field, reset 1
// - converters equal two to field, reset 1
// - octets per frame two to field
// - standby sends zeros or sync characters
// - test bit sends long test samples
// - sync bit selects dual alignment characters
// - mode 00 skips, 01 sends sequence once
// - mode 11 repeats sequence forever
// - alignment insertion on unless debug bit
//
// top of the transmit link configuration register bank, APB slave
// assumes APB master on pclk; lock pin is asynchronous to pclk
//
// Design decision made here: register access over APB.
`timescale 1ns/10ps
module jtxcf_regs (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    ce,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [jtxcf_pkg::ADDR_W-1:0] paddr,
  input  wire logic [jtxcf_pkg::DATA_W-1:0] pwdata,
  input  wire logic [3:0]              pstrb,
  input  wire logic                    pll_lock_pin,
  output logic [jtxcf_pkg::DATA_W-1:0] prdata,
  output logic                         pready,
  output logic                         pslverr,
  output logic [3:0]                   lane_num,
  output logic [7:0]                   conv_num,
  output logic [7:0]                   octet_num,
  output logic                         stby_sync_chars,
  output logic                         tail_pn_en,
  output logic                         ltpl_test_en,
  output logic                         fa_dual_chars,
  output logic                         ilas_once,
  output logic                         dl_test_mode,
  output logic                         fa_insert_en,
  output logic                         link_pdn
);
  import jtxcf_pkg::*;

  jtxcf_byte_t quick_q;
  jtxcf_byte_t ctrl_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [DATA_W-1:0] prdata_q;
  logic        lock_s1_q;
  logic        lock_s2_q;
  logic        lock_s3_q;
  logic        lock_q;

  //////////////////////////////////////////////////////////////////////
  // address decode and phase qualifiers
  wire logic hit_quick = (paddr == ADDR_QUICK);
  wire logic hit_ctrl  = (paddr == ADDR_CTRL);
  wire logic hit_pll   = (paddr == ADDR_PLL);
  wire logic hit_any   = hit_quick | hit_ctrl | hit_pll;
  wire logic setup_ph  = psel & ~penable;
  wire logic commit    = psel & penable & pready_q;
  // answer owed: a setup edge missed while ce was low is still answered
  wire logic answer_d  = psel & ~pready_q;
  // writes need lane 0 strobe; status is read-only and errors on write
  wire logic wr_ok     = commit & pwrite & pstrb[0];
  wire logic wr_quick  = wr_ok & hit_quick;
  wire logic wr_ctrl   = wr_ok & hit_ctrl;
  wire logic err_d     = ~hit_any | (pwrite & hit_pll);

  // read mux, upper bits read zero
  wire jtxcf_byte_t pll_view = jtxcf_byte_t'({lock_q, 7'h00});
  wire jtxcf_byte_t rd_byte  = hit_quick ? quick_q :
                               hit_ctrl  ? ctrl_q  :
                               hit_pll   ? pll_view : 8'h00;
  wire logic [DATA_W-1:0] rd_word = {24'h00_0000, rd_byte};

  //////////////////////////////////////////////////////////////////////
  // answer registers: ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (ce) begin
      pready_q  <= answer_d;
      pslverr_q <= answer_d & err_d;
      prdata_q  <= (answer_d & ~pwrite) ? rd_word : 32'h0000_0000;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // quick setup register
  // lane, converter and octet fields stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quick_q <= RST_QUICK;
    end else if (ce && wr_quick) begin
      quick_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= RST_CTRL;
    end else if (ce && wr_ctrl) begin
      ctrl_q <= pwdata[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // lock pin synchroniser, change counts when stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_s1_q <= 1'b0;
      lock_s2_q <= 1'b0;
      lock_s3_q <= 1'b0;
      lock_q    <= 1'b0;
    end else if (ce) begin
      lock_s1_q <= pll_lock_pin;
      lock_s2_q <= lock_s1_q;
      lock_s3_q <= lock_s2_q;
      if (lock_s2_q == lock_s3_q) begin
        lock_q <= lock_s3_q;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // decoder fed through the carrier interface
  jtxcf_cfg_if cfg_bus ();
  assign cfg_bus.quick_q = quick_q;
  assign cfg_bus.ctrl_q  = ctrl_q;
  assign cfg_bus.ce      = ce;

  jtxcf_decode i_jtxcf_decode (
    .pclk            (pclk),
    .presetn         (presetn),
    .cfg             (cfg_bus),
    .lane_num        (lane_num),
    .conv_num        (conv_num),
    .octet_num       (octet_num),
    .stby_sync_chars (stby_sync_chars),
    .tail_pn_en      (tail_pn_en),
    .ltpl_test_en    (ltpl_test_en),
    .fa_dual_chars   (fa_dual_chars),
    .ilas_once       (ilas_once),
    .dl_test_mode    (dl_test_mode),
    .fa_insert_en    (fa_insert_en),
    .link_pdn        (link_pdn)
  );

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  //////////////////////////////////////////////////////////////////////
  // bus and register checks
  ready_timing_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && setup_ph |=> pready)
    else $error("no ready one cycle after setup");
  ready_once_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready && ce |=> !pready)
    else $error("ready held longer than one cycle");
  quick_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && wr_quick |=> quick_q == $past(pwdata[7:0]))
    else $error("quick setup write lost");
  ctrl_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && wr_ctrl ##1 ce |=> stby_sync_chars == $past(pwdata[STBY_BIT], 2))
    else $error("standby select not applied");
  tail_path_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && wr_ctrl ##1 ce |=> tail_pn_en == $past(pwdata[TAIL_BIT], 2))
    else $error("tail fill enable not applied");
  test_path_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && wr_ctrl ##1 ce |=> ltpl_test_en == $past(pwdata[LTPL_BIT], 2))
    else $error("test sample enable not applied");
  unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && setup_ph && !hit_any |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped address not refused");
  // paths from a control write to the decoded controls
  dual_path_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && wr_ctrl ##1 ce |=> fa_dual_chars == $past(pwdata[LSYN_BIT], 2))
    else $error("alignment character select not applied");
  once_path_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && wr_ctrl ##1 ce |=> ilas_once == ($past(pwdata[ILAS_LSB +: 2], 2) == ILAS_ONCE))
    else $error("single sequence mode not applied");
  loop_path_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && wr_ctrl ##1 ce |=> dl_test_mode == ($past(pwdata[ILAS_LSB +: 2], 2) == ILAS_LOOP))
    else $error("repeated sequence mode not applied");
  insert_path_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && wr_ctrl ##1 ce |=> fa_insert_en == !$past(pwdata[FACI_BIT], 2))
    else $error("alignment insertion not applied");
  // bus refusals, late answers, read data and lock filter
  late_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && psel && penable && !pready |=> pready)
    else $error("access without ready not answered");
  status_refuse_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && setup_ph && pwrite && hit_pll |=> pslverr)
    else $error("status write not refused");
  strobe_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && commit && pwrite && !pstrb[0] |=> $stable(quick_q) && $stable(ctrl_q))
    else $error("write without lane 0 strobe stored");
  ctrl_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && setup_ph && !pwrite && hit_ctrl |=> prdata == {24'h00_0000, $past(ctrl_q)})
    else $error("control register read data wrong");
  lock_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && lock_s2_q == lock_s3_q |=> lock_q == $past(lock_s3_q))
    else $error("lock status not following agreed stages");
  write_cover_c: cover property (@(posedge pclk) disable iff (!presetn) wr_ctrl);
  read_cover_c: cover property (@(posedge pclk) disable iff (!presetn)
    commit && !pwrite && hit_quick);
  lock_cover_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(lock_q));
endmodule : jtxcf_regs

// ### rtl/jtxcf_pkg.sv
// package for the transmit link configuration register bank
// assumes an APB slave with 32-bit data and byte addresses of 16 bits
package jtxcf_pkg;

  // bus and register geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;

  // register indices; byte address is four times the index
  localparam logic [13:0] IDX_PLL   = 14'h056f;
  localparam logic [13:0] IDX_QUICK = 14'h0570;
  localparam logic [13:0] IDX_CTRL  = 14'h0571;
  localparam logic [15:0] ADDR_PLL   = {IDX_PLL, 2'b00};
  localparam logic [15:0] ADDR_QUICK = {IDX_QUICK, 2'b00};
  localparam logic [15:0] ADDR_CTRL  = {IDX_CTRL, 2'b00};

  // values after reset
  localparam logic [7:0] RST_QUICK = 8'h49;
  localparam logic [7:0] RST_CTRL  = 8'h14;

  // quick setup fields
  localparam int L_LSB = 6;
  localparam int M_LSB = 3;
  localparam int F_LSB = 0;

  // first control register fields
  localparam int STBY_BIT = 7;
  localparam int TAIL_BIT = 6;
  localparam int LTPL_BIT = 5;
  localparam int LSYN_BIT = 4;
  localparam int ILAS_LSB = 2;
  localparam int FACI_BIT = 1;
  localparam int PDN_BIT  = 0;

  // serializer state register field
  localparam int LOCK_BIT = 7;

  // alignment sequence mode codes
  localparam logic [1:0] ILAS_OFF  = 2'b00;
  localparam logic [1:0] ILAS_ONCE = 2'b01;
  localparam logic [1:0] ILAS_LOOP = 2'b11;

  typedef logic [7:0] jtxcf_byte_t;

endpackage : jtxcf_pkg

// ### rtl/jtxcf_cfg_if.sv
// carries stored register contents from the bus slave to the decoder
// assumes both ends sit on pclk with the same clock enable
`timescale 1ns/10ps
interface jtxcf_cfg_if;
  import jtxcf_pkg::*;
  jtxcf_byte_t quick_q;
  jtxcf_byte_t ctrl_q;
  logic        ce;
  modport src (output quick_q, output ctrl_q, output ce);
  modport dst (input quick_q, input ctrl_q, input ce);
endinterface : jtxcf_cfg_if

// ### rtl/jtxcf_decode.sv
// registered decode of the link configuration into framer controls
// assumes register contents arrive on pclk through jtxcf_cfg_if
`timescale 1ns/10ps
module jtxcf_decode (
  input  wire logic  pclk,
  input  wire logic  presetn,
  jtxcf_cfg_if.dst   cfg,
  output logic [3:0] lane_num,
  output logic [7:0] conv_num,
  output logic [7:0] octet_num,
  output logic       stby_sync_chars,
  output logic       tail_pn_en,
  output logic       ltpl_test_en,
  output logic       fa_dual_chars,
  output logic       ilas_once,
  output logic       dl_test_mode,
  output logic       fa_insert_en,
  output logic       link_pdn
);
  import jtxcf_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // field extraction
  wire logic [1:0] lane_code = cfg.quick_q[L_LSB +: 2];
  wire logic [2:0] conv_code = cfg.quick_q[M_LSB +: 3];
  wire logic [2:0] oct_code  = cfg.quick_q[F_LSB +: 3];
  wire logic [1:0] ilas_code = cfg.ctrl_q[ILAS_LSB +: 2];

  wire logic [3:0] lane_d  = 4'h1 << lane_code;
  wire logic [7:0] conv_d  = 8'h01 << conv_code;
  wire logic [7:0] oct_d   = 8'h01 << oct_code;

  //////////////////////////////////////////////////////////////////////
  // output registers, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lane_num        <= 4'h2;
      conv_num        <= 8'h02;
      octet_num       <= 8'h02;
      stby_sync_chars <= 1'b0;
      tail_pn_en      <= 1'b0;
      ltpl_test_en    <= 1'b0;
      fa_dual_chars   <= 1'b1;
      ilas_once       <= 1'b1;
      dl_test_mode    <= 1'b0;
      fa_insert_en    <= 1'b1;
      link_pdn        <= 1'b0;
    end else if (cfg.ce) begin
      lane_num        <= lane_d;
      conv_num        <= conv_d;
      octet_num       <= oct_d;
      stby_sync_chars <= cfg.ctrl_q[STBY_BIT];
      tail_pn_en      <= cfg.ctrl_q[TAIL_BIT];
      ltpl_test_en    <= cfg.ctrl_q[LTPL_BIT];
      fa_dual_chars   <= cfg.ctrl_q[LSYN_BIT];
      ilas_once       <= (ilas_code == ILAS_ONCE);
      dl_test_mode    <= (ilas_code == ILAS_LOOP);
      fa_insert_en    <= ~cfg.ctrl_q[FACI_BIT];
      link_pdn        <= cfg.ctrl_q[PDN_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks on decode
  lane_decode_a: assert property (@(posedge pclk) disable iff (!presetn)
    cfg.ce |=> lane_num == (4'h1 << $past(lane_code)))
    else $error("lane count does not follow lane field");
  conv_decode_a: assert property (@(posedge pclk) disable iff (!presetn)
    cfg.ce |=> conv_num == (8'h01 << $past(conv_code)))
    else $error("converter count does not follow field");
  octet_decode_a: assert property (@(posedge pclk) disable iff (!presetn)
    cfg.ce && oct_code == 3'h3 |=> octet_num == 8'h08)
    else $error("octet count wrong for code 3");
  ilas_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    cfg.ce && ilas_code == ILAS_OFF |=> !ilas_once && !dl_test_mode)
    else $error("sequence not skipped for mode 00");
  loop_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    cfg.ce && ilas_code == ILAS_LOOP |=> dl_test_mode && !ilas_once)
    else $error("test mode not entered for mode 11");
  fa_insert_a: assert property (@(posedge pclk) disable iff (!presetn)
    cfg.ce |=> fa_insert_en != $past(cfg.ctrl_q[FACI_BIT]))
    else $error("alignment insertion enable inverted");
  freeze_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !cfg.ce |=> $stable(fa_dual_chars) && $stable(stby_sync_chars) && $stable(lane_num))
    else $error("decode moved while clock enable low");
  loop_mode_c: cover property (@(posedge pclk) disable iff (!presetn) dl_test_mode);
endmodule : jtxcf_decode

// ### sim/testbench.sv
// self-checking bench for the transmit link configuration register bank
// assumes jtxcf_regs on pclk at 20 MHz, driven here as the only APB master
`timescale 1ns/10ps
module testbench;
  import jtxcf_pkg::*;
  logic              pclk, presetn, ce, psel, penable, pwrite, pll_lock_pin;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [3:0]        pstrb, lane_num;
  logic [7:0]        conv_num, octet_num;
  logic              pready, pslverr, err, stby_sync_chars, tail_pn_en, ltpl_test_en;
  logic              fa_dual_chars, ilas_once, dl_test_mode, fa_insert_en, link_pdn;
  int                miscompares, n_tests, cycles;
  wire  [7:0]        ctl_out = {stby_sync_chars, tail_pn_en, ltpl_test_en, fa_dual_chars,
                                ilas_once, dl_test_mode, fa_insert_en, link_pdn};

  jtxcf_regs i_jtxcf_regs (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pll_lock_pin(pll_lock_pin), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lane_num(lane_num), .conv_num(conv_num), .octet_num(octet_num),
    .stby_sync_chars(stby_sync_chars), .tail_pn_en(tail_pn_en), .ltpl_test_en(ltpl_test_en),
    .fa_dual_chars(fa_dual_chars), .ilas_once(ilas_once), .dl_test_mode(dl_test_mode),
    .fa_insert_en(fa_insert_en), .link_pdn(link_pdn));

  ////////////////////////////////////////////////////////////////////////////////
  // clock, reset and hang guard
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      $display("ERROR %0t: timeout", $time);
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bus cycles and comparison
  task automatic chk(input logic [31:0] act, input logic [31:0] exp, input string what);
    n_tests++;
    if (act !== exp) begin
      miscompares++;
      $display("ERROR %0t: %s got %h want %h", $time, what, act, exp);
    end
  endtask : chk

  // setup, access held until pready is seen at an edge, released at that edge
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // config outputs follow the register one edge after it stores
  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask : settle

  function automatic logic [7:0] ctl_exp(input logic [7:0] c);
    return {c[7], c[6], c[5], c[4], c[3:2] == 2'b01, c[3:2] == 2'b11, !c[1], c[0]};
  endfunction : ctl_exp

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    #1;
    chk(32'(lane_num), 32'h0000_0002, "lanes");
    chk(32'(conv_num), 32'h0000_0002, "converters");
    chk(32'(octet_num), 32'h0000_0002, "octets");
    chk(32'(ctl_out), 32'(ctl_exp(RST_CTRL)), "ctl");
    apb(1'b0, ADDR_QUICK, 32'h0000_0000, 4'h0);
    chk(rd, 32'(RST_QUICK), "quick reset");
    apb(1'b0, ADDR_CTRL, 32'h0000_0000, 4'h0);
    chk(rd, 32'(RST_CTRL), "ctrl reset");
    $display("test reset done");
  endtask : t_reset

  // every listed lane, converter and frame-size code
  task automatic t_quick();
    logic [7:0] q;
    // only listed lane, converter and frame codes driven
    for (int l = 0; l < 2; l++) for (int m = 0; m < 3; m++) for (int f = 0; f < 4; f++) begin
      q = {l[1:0], m[2:0], f[2:0]};
      apb(1'b1, ADDR_QUICK, 32'(q), 4'hf);
      settle();
      chk(32'(lane_num), 32'(1 << l), "lanes");
      chk(32'(conv_num), 32'(1 << m), "converters");
      chk(32'(octet_num), 32'(1 << f), "octets");
      apb(1'b0, ADDR_QUICK, 32'h0000_0000, 4'h0);
      chk(rd, 32'(q), "quick readback");
    end
    $display("test quick done");
  endtask : t_quick

  // each control bit alone plus every listed sequence mode
  task automatic t_ctrl();
    logic [7:0] tbl [9] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h00, 8'h04, 8'h0c, 8'h02, 8'h01};
    foreach (tbl[i]) begin
      apb(1'b1, ADDR_CTRL, 32'(tbl[i]), 4'hf);
      settle();
      chk(32'(ctl_out), 32'(ctl_exp(tbl[i])), "ctl");
      apb(1'b0, ADDR_CTRL, 32'h0000_0000, 4'h0);
      chk(rd, 32'(tbl[i]), "ctrl readback");
    end
    $display("test ctrl done");
  endtask : t_ctrl

  // unmapped read, status write, masked write, upper bits dropped
  task automatic t_refuse();
    apb(1'b0, 16'h1000, 32'h0000_0000, 4'h0);
    chk({rd[31:1], err}, 32'h0000_0001, "unmapped");
    apb(1'b1, ADDR_PLL, 32'h0000_00ff, 4'hf);
    chk(32'(err), 32'h0000_0001, "status write");
    apb(1'b1, ADDR_CTRL, 32'h1234_5681, 4'hf);
    apb(1'b1, ADDR_CTRL, 32'h0000_0000, 4'he);
    settle();
    chk(32'(ctl_out), 32'(ctl_exp(8'h81)), "masked write");
    apb(1'b0, ADDR_CTRL, 32'h0000_0000, 4'h0);
    chk({rd[31:1], err}, 32'h0000_0080, "ctrl upper");
    $display("test refuse done");
  endtask : t_refuse

  // lock pin through to status bit 7, and a frozen clock enable
  task automatic t_lock_ce();
    pll_lock_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b0, ADDR_PLL, 32'h0000_0000, 4'h0);
    chk(rd, 32'h0000_0080, "locked");
    fork
      apb(1'b1, ADDR_QUICK, 32'h0000_0012, 4'hf);
      begin
        ce <= 1'b0;
        repeat (4) @(posedge pclk);
        ce <= 1'b1;
      end
    join
    settle();
    chk({28'h000_0000, lane_num}, 32'h0000_0001, "ce lanes");
    chk(32'(conv_num), 32'h0000_0004, "ce converters");
    $display("test lock_ce done");
  endtask : t_lock_ce

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence and verdict
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    {presetn, ce, psel, penable, pwrite, pll_lock_pin} = 6'b010000;
    paddr = 16'h0000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_quick();
    t_ctrl();
    t_refuse();
    t_lock_ce();
    stop_test();
  end
endmodule : testbench
